// ---- pms_power_seq.sv ----
`timescale 1ns/1ps
module pms_power_seq
  import pms_pkg::*;
#(
  parameter int INIT_CYC = pms_pkg::INIT_CYCLES,
  parameter int WAKE_CYC = pms_pkg::WAKE_CYCLES,
  parameter int RAMP_CYC = pms_pkg::RAMP_CYCLES
)
(
  // system
  input wire logic ref_clk,
  input wire logic rst_n,
  // hardware shutdown pin
  input wire logic shutdown_n_pin,
  // control bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // audio serial port
  input wire logic bit_clock,
  input wire logic frame_sync,
  output logic sdout_data,
  output logic sdout_oe_n,
  // microphone pins
  input wire logic [N_LINES-1:0] general_input,
  output logic [N_LINES-1:0] general_output,
  // power and status
  output logic analog_regulator_en,
  output logic mic_bias_supply_en,
  output logic adc_power_en,
  output logic pll_power_en,
  output logic sleep_done_flag,
  output pms_pkg::pms_mode_e power_mode
);
  import pms_pkg::*;

  typedef enum logic [3:0] {
    I_IDLE = 4'h0,
    I_ADDR = 4'h1,
    I_AACK = 4'h3,
    I_REG = 4'h2,
    I_RACK = 4'h6,
    I_WR = 4'h7,
    I_WACK = 4'h5,
    I_RD = 4'h4,
    I_MACK = 4'hc
  } pms_i2c_e;

  logic [1:0] shdn_s;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [N_LINES-1:0] gpi_s1;
  logic [N_LINES-1:0] gpi_s2;
  logic [2:0] fr_s;
  logic hw_rst;
  logic scl;
  logic sda;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  pms_mode_e state_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [7:0] cfg_reg [REG_N];
  pms_i2c_e i2c_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic byte_done_reg;
  logic wr_stb;
  logic bus_open;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic awake_req;
  logic powered;
  logic capturing;
  logic [MIC_DIV_W-1:0] div_reg;
  logic mic_clk_reg;
  logic mic_edge;
  logic [N_LINES-1:0] line_bit;
  logic [N_CH-1:0] ch_on;
  logic [ACC_W-1:0] acc_reg [N_CH];
  logic [N_CH*ACC_W-1:0] hold_reg;
  logic [N_CH-1:0] hold_slots_reg;
  logic hold_tog_reg;
  logic active_lvl_reg;
  logic frame_ev;
  logic frame_tog;

  // pins pass two flops before use
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      shdn_s <= 2'h0;
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      gpi_s1 <= '0;
      gpi_s2 <= '0;
      fr_s <= 3'h0;
    end
    else
    begin
      shdn_s <= {shdn_s[0], shutdown_n_pin};
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      gpi_s1 <= general_input;
      gpi_s2 <= gpi_s1;
      fr_s <= {fr_s[1:0], frame_tog};
    end
  end

  assign hw_rst = ~rst_n | ~shdn_s[1];
  assign scl = scl_s[1];
  assign sda = sda_s[1];
  assign rise = scl & ~scl_s[2];
  assign fall = ~scl & scl_s[2];
  assign start_ev = scl & scl_s[2] & sda_s[2] & ~sda;
  assign stop_ev = scl & scl_s[2] & ~sda_s[2] & sda;
  assign frame_ev = fr_s[1] ^ fr_s[2];

  // bit 0 wakes, bit 7 regulator
  assign awake_req = cfg_reg[IX_SLEEP][SLEEP_ENZ_BIT];
  assign powered = (state_reg == PMS_ACTIVE) || (state_reg == PMS_RAMP);
  assign bus_open = (state_reg != PMS_SHDN) && (state_reg != PMS_INIT);

  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      state_reg <= PMS_SHDN;
      tmr_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        PMS_SHDN:
        begin
          state_reg <= PMS_INIT;
          tmr_reg <= TMR_W'(INIT_CYC);
        end
        PMS_INIT:
        begin
          if (tmr_reg == '0)
            state_reg <= PMS_SLEEP;
          else
            tmr_reg <= tmr_reg - TMR_W'(1);
        end
        PMS_SLEEP:
        begin
          if (awake_req)
          begin
            state_reg <= PMS_WAKE;
            tmr_reg <= TMR_W'(WAKE_CYC);
          end
        end
        PMS_WAKE:
        begin
          if (!awake_req)
          begin
            state_reg <= PMS_RAMP;
            tmr_reg <= TMR_W'(RAMP_CYC);
          end
          else if (tmr_reg == '0)
            state_reg <= PMS_ACTIVE;
          else
            tmr_reg <= tmr_reg - TMR_W'(1);
        end
        PMS_ACTIVE:
        begin
          if (!awake_req)
          begin
            state_reg <= PMS_RAMP;
            tmr_reg <= TMR_W'(RAMP_CYC);
          end
        end
        PMS_RAMP:
        begin
          if (tmr_reg == '0)
            state_reg <= PMS_SLEEP;
          else
            tmr_reg <= tmr_reg - TMR_W'(1);
        end
        default:
        begin
          state_reg <= PMS_SHDN;
        end
      endcase
    end
  end

  assign status_byte = {(state_reg == PMS_SLEEP), 4'h0, state_reg};

  always_comb
  begin
    rd_byte = 8'h00;
    if (ptr_reg == ADDR_STATUS)
      rd_byte = status_byte;
    for (int i = 0; i < REG_N; i++)
    begin
      if (ptr_reg == REG_ADDR[i])
        rd_byte = cfg_reg[i];
    end
  end

  assign wr_stb = (i2c_reg == I_WR) && fall && byte_done_reg;

  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      for (int i = 0; i < REG_N; i++)
        cfg_reg[i] <= RST_CFG;
    end
    else if (wr_stb)
    begin
      for (int i = 0; i < REG_N; i++)
      begin
        if (ptr_reg == REG_ADDR[i])
          cfg_reg[i] <= rx_reg;
      end
    end
  end

  // open drain: a one is sent by releasing the line
  always_ff @(posedge ref_clk)
  begin
    if (hw_rst || stop_ev)
    begin
      i2c_reg <= I_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
      if (hw_rst)
      begin
        rx_reg <= 8'h00;
        tx_reg <= 8'h00;
        ptr_reg <= 8'h00;
        rw_reg <= 1'b0;
      end
    end
    else if (start_ev)
    begin
      i2c_reg <= I_ADDR;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      unique case (i2c_reg)
        I_IDLE:
        begin
          sda_oe_n <= 1'b1;
        end
        I_ADDR, I_REG, I_WR:
        begin
          if (rise)
          begin
            rx_reg <= {rx_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_done_reg <= (bit_cnt_reg == 3'h7);
          end
          else if (fall && byte_done_reg)
          begin
            byte_done_reg <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b0;
            if (i2c_reg == I_ADDR)
            begin
              rw_reg <= rx_reg[0];
              if (rx_reg[7:1] == I2C_DEV_ADDR && bus_open)
                i2c_reg <= I_AACK;
              else
              begin
                i2c_reg <= I_IDLE;
                sda_out <= 1'b1;
                sda_oe_n <= 1'b1;
              end
            end
            else if (i2c_reg == I_REG)
            begin
              ptr_reg <= rx_reg;
              i2c_reg <= I_RACK;
            end
            else
            begin
              ptr_reg <= ptr_reg + 8'h01;
              i2c_reg <= I_WACK;
            end
          end
        end
        I_AACK, I_MACK:
        begin
          if (rise && i2c_reg == I_MACK && sda)
            i2c_reg <= I_IDLE;
          else if (fall && (i2c_reg == I_MACK || rw_reg))
          begin
            sda_out <= rd_byte[7];
            sda_oe_n <= rd_byte[7];
            tx_reg <= {rd_byte[6:0], 1'b0};
            ptr_reg <= ptr_reg + 8'h01;
            bit_cnt_reg <= 3'h0;
            i2c_reg <= I_RD;
          end
          else if (fall)
          begin
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
            bit_cnt_reg <= 3'h0;
            i2c_reg <= I_REG;
          end
        end
        I_RACK, I_WACK:
        begin
          if (fall)
          begin
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
            bit_cnt_reg <= 3'h0;
            i2c_reg <= I_WR;
          end
        end
        I_RD:
        begin
          if (fall)
          begin
            if (bit_cnt_reg == 3'h7)
            begin
              sda_out <= 1'b1;
              sda_oe_n <= 1'b1;
              i2c_reg <= I_MACK;
            end
            else
            begin
              sda_out <= tx_reg[7];
              sda_oe_n <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
          end
        end
        default:
        begin
          i2c_reg <= I_IDLE;
        end
      endcase
    end
  end

  // power outputs follow the mode, so sleep drops them after the ramp
  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      analog_regulator_en <= 1'b0;
      mic_bias_supply_en <= 1'b0;
      adc_power_en <= 1'b0;
      pll_power_en <= 1'b0;
      sleep_done_flag <= 1'b0;
      power_mode <= PMS_SHDN;
    end
    else
    begin
      analog_regulator_en <= cfg_reg[IX_SLEEP][ANALOG_REGULATOR_SEL_BIT] & (powered | (state_reg == PMS_WAKE));
      // bias separate from adc and pll
      mic_bias_supply_en <= powered & cfg_reg[IX_PWR][PWR_BIAS_BIT];
      adc_power_en <= powered & cfg_reg[IX_PWR][PWR_ADC_BIT];
      pll_power_en <= powered & cfg_reg[IX_PWR][PWR_PLL_BIT];
      sleep_done_flag <= status_byte[STATUS_DONE_BIT];
      power_mode <= state_reg;
    end
  end

  assign capturing = powered & cfg_reg[IX_PWR][PWR_ADC_BIT];
  assign mic_edge = (div_reg == MIC_HALF_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (hw_rst || !capturing)
    begin
      div_reg <= '0;
      mic_clk_reg <= 1'b0;
    end
    else if (mic_edge)
    begin
      div_reg <= '0;
      mic_clk_reg <= ~mic_clk_reg;
    end
    else
      div_reg <= div_reg + MIC_DIV_W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
      general_output <= '0;
    else
    begin
      for (int k = 0; k < N_LINES; k++)
        general_output[k] <= mic_clk_reg &
          (cfg_reg[IX_GENERAL_OUTPUT_1+k][GPO_FN_LSB +: 4] == GPO_FN_MIC_CLK);
    end
  end

  // input nibble picks the data line
  always_comb
  begin
    line_bit = '0;
    for (int k = 0; k < N_LINES; k++)
    begin
      if (cfg_reg[IX_GPI12][7:4] == GPI_LINE_BASE + 4'(k))
        line_bit[k] = gpi_s2[0];
      if (cfg_reg[IX_GPI12][3:0] == GPI_LINE_BASE + 4'(k))
        line_bit[k] = gpi_s2[1];
      if (cfg_reg[IX_GPI34][7:4] == GPI_LINE_BASE + 4'(k))
        line_bit[k] = gpi_s2[2];
      if (cfg_reg[IX_GPI34][3:0] == GPI_LINE_BASE + 4'(k))
        line_bit[k] = gpi_s2[3];
    end
  end

  // first four channels need pdm source
  always_comb
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      ch_on[c] = capturing & cfg_reg[IX_IN_EN][N_CH-1-c];
      if (c < N_LINES)
        ch_on[c] = ch_on[c] & (cfg_reg[IX_SRC1+c][SRC_LSB +: 2] == SRC_PDM);
    end
  end

  // density count per frame stands in for the decimator; no gain
  // controller here, so nothing changes with the sample rate
  // no rate-dependent gain
  // two channels per line, one per clock edge
  always_ff @(posedge ref_clk)
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      if (hw_rst || frame_ev || !ch_on[c])
        acc_reg[c] <= '0;
      else if (mic_edge && (mic_clk_reg == c[0]))
        acc_reg[c] <= acc_reg[c] + ACC_W'(line_bit[c/2]);
    end
  end

  // bank handed over once per frame, toggle marks it stable
  always_ff @(posedge ref_clk)
  begin
    if (hw_rst)
    begin
      hold_reg <= '0;
      hold_slots_reg <= '0;
      hold_tog_reg <= 1'b0;
      active_lvl_reg <= 1'b0;
    end
    else
    begin
      active_lvl_reg <= (state_reg == PMS_ACTIVE) || (state_reg == PMS_RAMP);
      if (frame_ev)
      begin
        for (int c = 0; c < N_CH; c++)
          hold_reg[c*ACC_W +: ACC_W] <= acc_reg[c];
        // slot enables travel with the data
        hold_slots_reg <= cfg_reg[IX_SLOT_EN];
        hold_tog_reg <= ~hold_tog_reg;
      end
    end
  end

  pms_tdm_tx u_tdm
  (
    .bit_clock(bit_clock),
    .frame_sync(frame_sync),
    .rst_n(rst_n),
    .active_lvl(active_lvl_reg),
    .hold_words(hold_reg),
    .hold_slots(hold_slots_reg),
    .hold_tog(hold_tog_reg),
    .frame_tog(frame_tog),
    .sdout_data(sdout_data),
    .sdout_oe_n(sdout_oe_n)
  );
endmodule // pms_power_seq

// ---- pms_pkg.sv ----
// Function
// - after pin release the device initialises registers, then sleeps; host waits 1 ms
// - clearing sleep starts an internal wake-up sequence; host waits 1 ms
// - writing 0x81 to sleep control wakes the device using its analog regulator
// - input-channel enable at 0x73, channel 1 in the msb
// - output slot enable at 0x74, same per-channel bit layout
// - power-up at 0x75: 0xe0 adc, bias and pll; 0x60 leaves bias off
// - 0x40 in a channel source register at 0x3c/0x41/0x46/0x4b selects pdm input
// - 0x41 in output config 0x22 to 0x25 drives the mic bit clock on that pin
// - 0x45 at 0x2b and 0x67 at 0x2c map general inputs to mic data lines
// - each mic data line carries two channels, eight channels from four lines
// - frame of 256 bit clocks carrying 32-bit tdm channel words
// - sleep request ramps volume down and powers down blocks; host waits 6 ms
// - status register 119 bit 7 reports sleep done; host stops clocks only then
// - registers are kept in sleep; wake needs only the wake write and clocks
// - shutdown pin low forces hardware shutdown from any mode; release repeats sequence
// - as serial master, frame sync comes half a bit clock early
// - gain controller limited below 44.1 khz; do not rely on it there
package pms_pkg;
  localparam int CLK_MHZ = 125;
  localparam int INIT_TIME_US = 1000;
  localparam int WAKE_TIME_US = 1000;
  localparam int RAMP_TIME_US = 6000;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
  localparam int RAMP_CYCLES = RAMP_TIME_US * CLK_MHZ;
  localparam int TMR_W = 20;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h4c;
  localparam int N_CH = 8;
  localparam int N_LINES = 4;
  localparam int ACC_W = 16;
  localparam int SLOT_BITS = 32;
  localparam int FRAME_CNT_W = 8;
  localparam int MIC_DIV_W = 5;
  localparam logic [MIC_DIV_W-1:0] MIC_HALF_LAST = 5'h13;
  localparam int REG_N = 14;
  localparam int IX_SLEEP = 0;
  localparam int IX_GENERAL_OUTPUT_1 = 1;
  localparam int IX_GPI12 = 5;
  localparam int IX_GPI34 = 6;
  localparam int IX_SRC1 = 7;
  localparam int IX_IN_EN = 11;
  localparam int IX_SLOT_EN = 12;
  localparam int IX_PWR = 13;
  localparam logic [7:0] REG_ADDR [REG_N] = '{8'h02, 8'h22, 8'h23, 8'h24, 8'h25, 8'h2b, 8'h2c,
    8'h3c, 8'h41, 8'h46, 8'h4b, 8'h73, 8'h74, 8'h75};
  localparam logic [7:0] ADDR_STATUS = 8'h77;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam int SLEEP_ENZ_BIT = 0;
  localparam int ANALOG_REGULATOR_SEL_BIT = 7;
  localparam int PWR_BIAS_BIT = 7;
  localparam int PWR_ADC_BIT = 6;
  localparam int PWR_PLL_BIT = 5;
  localparam int SRC_LSB = 5;
  localparam logic [1:0] SRC_PDM = 2'h2;
  localparam int GPO_FN_LSB = 4;
  localparam logic [3:0] GPO_FN_MIC_CLK = 4'h4;
  localparam logic [3:0] GPI_LINE_BASE = 4'h4;
  localparam int STATUS_DONE_BIT = 7;
  typedef enum logic [2:0] {
    PMS_SHDN = 3'h0,
    PMS_INIT = 3'h1,
    PMS_SLEEP = 3'h3,
    PMS_WAKE = 3'h2,
    PMS_ACTIVE = 3'h6,
    PMS_RAMP = 3'h7
  } pms_mode_e;
endpackage

// ---- pms_tdm_tx.sv ----
`timescale 1ns/1ps
module pms_tdm_tx
  import pms_pkg::*;
(
  // link clock and frame
  input wire logic bit_clock,
  input wire logic frame_sync,
  // from system domain
  input wire logic rst_n,
  input wire logic active_lvl,
  input wire logic [N_CH*ACC_W-1:0] hold_words,
  input wire logic [N_CH-1:0] hold_slots,
  input wire logic hold_tog,
  // back to system domain
  output logic frame_tog,
  // serial data pin
  output logic sdout_data,
  output logic sdout_oe_n
);
  import pms_pkg::*;
  logic [1:0] rst_s;
  logic [1:0] act_s;
  logic [2:0] tog_s;
  logic fs_prev_reg;
  logic [FRAME_CNT_W-1:0] cnt_reg;
  logic [SLOT_BITS-1:0] shift_reg;
  logic [N_CH*ACC_W-1:0] bank_reg;
  logic [N_CH-1:0] slots_reg;
  logic start;
  logic [2:0] slot_next;
  logic [SLOT_BITS-1:0] word;
  logic link_rst;

  always_ff @(posedge bit_clock)
  begin
    rst_s <= {rst_s[0], rst_n};
    act_s <= {act_s[0], active_lvl};
    tog_s <= {tog_s[1:0], hold_tog};
  end
  assign link_rst = ~rst_s[1];
  // only ever a target here: the frame sync is taken as the host drives it,
  // so the early frame sync of the master mode never arises
  // target timing only
  assign start = frame_sync & ~fs_prev_reg;
  assign slot_next = start ? 3'h0 : cnt_reg[FRAME_CNT_W-1:5];
  assign word = {bank_reg[slot_next*ACC_W +: ACC_W], {(SLOT_BITS-ACC_W){1'b0}}};

  // bank copied only once the toggle change has passed the two synchroniser flops
  always_ff @(posedge bit_clock)
  begin
    if (link_rst)
    begin
      bank_reg <= '0;
      slots_reg <= '0;
    end
    else if (tog_s[2] ^ tog_s[1])
    begin
      bank_reg <= hold_words;
      slots_reg <= hold_slots;
    end
  end

  always_ff @(posedge bit_clock)
  begin
    if (link_rst)
    begin
      fs_prev_reg <= 1'b0;
      cnt_reg <= '0;
      shift_reg <= '0;
      frame_tog <= 1'b0;
      sdout_data <= 1'b0;
      sdout_oe_n <= 1'b1;
    end
    else
    begin
      fs_prev_reg <= frame_sync;
      if (start)
      begin
        frame_tog <= ~frame_tog;
        cnt_reg <= FRAME_CNT_W'(1);
      end
      else
      begin
        cnt_reg <= cnt_reg + FRAME_CNT_W'(1);
      end
      if (start || cnt_reg[4:0] == 5'h00)
      begin
        sdout_data <= word[SLOT_BITS-1];
        shift_reg <= {word[SLOT_BITS-2:0], 1'b0};
      end
      else
      begin
        sdout_data <= shift_reg[SLOT_BITS-1];
        shift_reg <= {shift_reg[SLOT_BITS-2:0], 1'b0};
      end
      sdout_oe_n <= ~(act_s[1] & slots_reg[3'h7 - slot_next]);
    end
  end
endmodule // pms_tdm_tx

// ---- pms_power_seq_monitor.sv ----
`timescale 1ns/1ps
module pms_power_seq_monitor
  import pms_pkg::*;
#(
  parameter int INIT_CYC = 20,
  parameter int WAKE_CYC = 20,
  parameter int RAMP_CYC = 40
)
(
  // clock, reset, pin
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic shutdown_n_pin,
  // power and status
  input wire logic analog_regulator_en,
  input wire logic mic_bias_supply_en,
  input wire logic adc_power_en,
  input wire logic pll_power_en,
  input wire logic sleep_done_flag,
  input wire pms_pkg::pms_mode_e power_mode
);
  // spans counted from the eighth cycle of each timed mode
  localparam int INIT_D = INIT_CYC - 7;
  localparam int WAKE_D = WAKE_CYC - 7;
  localparam int RAMP_D = RAMP_CYC - 7;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence init_end_s;
    (power_mode == PMS_INIT) [*8] ##[INIT_D:INIT_D] power_mode == PMS_INIT ##1 power_mode == PMS_SLEEP;
  endsequence
  sequence wake_end_s;
    (power_mode == PMS_WAKE) [*8] ##[WAKE_D:WAKE_D] power_mode == PMS_WAKE ##1 power_mode == PMS_ACTIVE;
  endsequence
  sequence ramp_end_s;
    (power_mode == PMS_RAMP) [*8] ##[RAMP_D:RAMP_D] power_mode == PMS_RAMP ##1 power_mode == PMS_SLEEP;
  endsequence
  shdn_force_a: assert property ((!shutdown_n_pin) [*4] |=> power_mode == PMS_SHDN)
    else $error("mode not shutdown after pin low");
  shdn_quiet_a: assert property ((power_mode == PMS_SHDN) [*2] |-> !adc_power_en && !analog_regulator_en)
    else $error("power enabled in shutdown");
  init_seq_a: assert property ($rose(power_mode == PMS_INIT) |-> init_end_s)
    else $error("init span wrong");
  wake_seq_a: assert property ($rose(power_mode == PMS_WAKE) |-> wake_end_s)
    else $error("wake span wrong");
  ramp_seq_a: assert property ($rose(power_mode == PMS_RAMP) |-> ramp_end_s)
    else $error("ramp span wrong");
  done_flag_a: assert property (power_mode == $past(power_mode) |-> sleep_done_flag == (power_mode == PMS_SLEEP))
    else $error("done flag wrong");
  power_gate_a: assert property (adc_power_en || pll_power_en || mic_bias_supply_en |->
    power_mode inside {PMS_ACTIVE, PMS_RAMP} || $past(power_mode) inside {PMS_ACTIVE, PMS_RAMP})
    else $error("block powered outside active");
  analog_regulator_gate_a: assert property (analog_regulator_en |->
    !(power_mode inside {PMS_SHDN, PMS_INIT}) || $past(power_mode) inside {PMS_WAKE, PMS_ACTIVE, PMS_RAMP})
    else $error("regulator on while off");
endmodule // pms_power_seq_monitor

bind pms_power_seq pms_power_seq_monitor #(.INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC), .RAMP_CYC(RAMP_CYC)) mon_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .shutdown_n_pin(shutdown_n_pin), .analog_regulator_en(analog_regulator_en),
  .mic_bias_supply_en(mic_bias_supply_en), .adc_power_en(adc_power_en), .pll_power_en(pll_power_en),
  .sleep_done_flag(sleep_done_flag), .power_mode(power_mode));

// ---- pms_host_model.sv ----
`timescale 1ns/1ps
module pms_host_model
  import pms_pkg::*;
(
  // system
  input wire logic ref_clk,
  input wire logic tdm_on,
  // control bus
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl_in,
  output logic sda_in,
  // audio serial port
  input wire logic sdout_data,
  input wire logic sdout_oe_n,
  output logic bit_clock,
  output logic frame_sync,
  output logic [N_CH-1:0] slot_on,
  output logic [N_CH*SLOT_BITS-1:0] words
);
  logic sda_drv;
  logic [7:0] cnt;
  logic [SLOT_BITS-1:0] sh;
  // open drain: low if either side pulls
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  // clock only while enabled, 256 per frame
  initial
  begin
    scl_in = 1'b1;
    sda_drv = 1'b1;
    frame_sync = 1'b0;
    cnt = 8'h00;
    bit_clock = 1'b0;
    #3.3;
    forever #6 bit_clock = tdm_on & ~bit_clock;
  end
  // sample on falling edge; cnt is the bit just sent
  always @(negedge bit_clock)
  begin
    cnt <= cnt + 8'h01;
    frame_sync <= (cnt == 8'hff);
    sh <= {sh[30:0], sdout_data ^ sdout_oe_n};
    if (cnt[4:0] == 5'h00)
      slot_on[cnt[7:5]] <= ~sdout_oe_n;
    if (cnt[4:0] == 5'h1f)
      words[cnt[7:5]*SLOT_BITS +: SLOT_BITS] <= {sh[30:0], sdout_data ^ sdout_oe_n};
  end
  // data moves only while scl is low
  task automatic bit_x(input logic d, output logic r);
    scl_in <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sda_drv <= d;
    repeat (4) @(posedge ref_clk);
    scl_in <= 1'b1;
    repeat (5) @(posedge ref_clk);
    r = sda_in;
  endtask
  task automatic xfer(input logic [7:0] w, input logic m_ack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_x(w[i], r[i]);
    bit_x(m_ack, ack);
  endtask
  // a=1,b=0 gives start; a=0,b=1 gives stop
  task automatic edge2(input logic a, input logic b);
    scl_in <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sda_drv <= a;
    repeat (3) @(posedge ref_clk);
    scl_in <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sda_drv <= b;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic a1, a2, a3;
    edge2(1'b1, 1'b0);
    xfer(dev, 1'b1, r, a1);
    xfer(ptr, 1'b1, r, a2);
    xfer(d, 1'b1, r, a3);
    edge2(1'b0, 1'b1);
    ack = a1 | a2 | a3;
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    edge2(1'b1, 1'b0);
    xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer(ptr, 1'b1, r, a);
    edge2(1'b1, 1'b0);
    xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, r, a);
    xfer(8'hff, 1'b1, d, a);
    edge2(1'b0, 1'b1);
  endtask
endmodule // pms_host_model

// ---- tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb;
  import pms_pkg::*;
  localparam logic [7:0] CFG_A [12] = '{8'h3c, 8'h41, 8'h46, 8'h4b, 8'h22, 8'h23, 8'h24, 8'h25,
    8'h2b, 8'h2c, 8'h73, 8'h74};
  localparam logic [7:0] CFG_D [12] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h41, 8'h41, 8'h41, 8'h41,
    8'h45, 8'h67, 8'hff, 8'hf0};
  logic ref_clk, rst_n, shutdown_n_pin, tdm_on, ack;
  logic scl_in, sda_in, sda_out, sda_oe_n, bit_clock, frame_sync, sdout_data, sdout_oe_n;
  logic analog_regulator_en, mic_bias_supply_en, adc_power_en, pll_power_en, sleep_done_flag;
  logic [N_LINES-1:0] general_input, general_output, hi, lo;
  logic [N_CH-1:0] slot_on;
  logic [N_CH*SLOT_BITS-1:0] words;
  logic [7:0] rdata;
  pms_mode_e power_mode;
  int error_cnt = 0;
  int num_checks = 0;
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  pms_power_seq #(.INIT_CYC(20), .WAKE_CYC(20), .RAMP_CYC(40)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .shutdown_n_pin(shutdown_n_pin), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .bit_clock(bit_clock), .frame_sync(frame_sync), .sdout_data(sdout_data),
    .sdout_oe_n(sdout_oe_n), .general_input(general_input), .general_output(general_output),
    .analog_regulator_en(analog_regulator_en), .mic_bias_supply_en(mic_bias_supply_en),
    .adc_power_en(adc_power_en), .pll_power_en(pll_power_en), .sleep_done_flag(sleep_done_flag),
    .power_mode(power_mode));
  pms_host_model host_u (.ref_clk(ref_clk), .tdm_on(tdm_on), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl_in(scl_in), .sda_in(sda_in), .sdout_data(sdout_data), .sdout_oe_n(sdout_oe_n),
    .bit_clock(bit_clock), .frame_sync(frame_sync), .slot_on(slot_on), .words(words));
  task automatic wait_mode(input pms_mode_e m, input int lim);
    int n = 0;
    while (power_mode !== m && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("power_mode", m, power_mode)
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host_u.wr({I2C_DEV_ADDR, 1'b0}, a, d, ack);
    `CHK("ack", 1'b0, ack)
  endtask
  task automatic creg(input logic [7:0] a, input logic [7:0] d);
    host_u.rd(a, rdata);
    `CHK("reg", d, rdata)
  endtask
  task automatic t_power_up;
    `CHK("mode_shdn", PMS_SHDN, power_mode)
    shutdown_n_pin <= 1'b1;
    // no bus traffic until sleep shows
    wait_mode(PMS_SLEEP, 100);
    `CHK("done_flag", 1'b1, sleep_done_flag)
    host_u.wr(8'ha0, 8'h02, 8'h81, ack);
    `CHK("bad_addr_nack", 1'b1, ack)
  endtask
  task automatic t_wake;
    wreg(8'h02, 8'h81);
    wait_mode(PMS_ACTIVE, 60);
    `CHK("regulator", 1'b1, analog_regulator_en)
    creg(8'h77, 8'h06);
  endtask
  task automatic t_config;
    for (int i = 0; i < 12; i++)
      wreg(CFG_A[i], CFG_D[i]);
    for (int i = 0; i < 12; i++)
      creg(CFG_A[i], CFG_D[i]);
    wreg(8'h50, 8'h5a);
    creg(8'h50, 8'h00);
    wreg(8'h77, 8'h00);
    creg(8'h77, 8'h06);
    wreg(8'h75, 8'h60);
    `CHK("bias_off", 3'b011, {mic_bias_supply_en, adc_power_en, pll_power_en})
    wreg(8'h75, 8'he0);
    `CHK("bias_on", 3'b111, {mic_bias_supply_en, adc_power_en, pll_power_en})
    hi = '0;
    lo = '1;
    repeat (100)
    begin
      @(posedge ref_clk);
      hi = hi | general_output;
      lo = lo & general_output;
    end
    `CHK("mic_clk_hi", 4'hf, hi)
    `CHK("mic_clk_lo", 4'h0, lo)
  endtask
  task automatic t_audio;
    general_input <= 4'b0101;
    tdm_on <= 1'b1;
    repeat (2000) @(posedge ref_clk);
    `CHK("slots_f0", 8'h0f, slot_on)
    wreg(8'h74, 8'hff);
    repeat (2000) @(posedge ref_clk);
    `CHK("slots_ff", 8'hff, slot_on)
    for (int n = 0; n < N_CH; n++)
    begin
      `CHK("word_hi", (n % 4) < 2, words[n*SLOT_BITS+16 +: 16] != 16'h0)
      `CHK("word_lo", 16'h0, words[n*SLOT_BITS +: 16])
    end
  endtask
  task automatic t_sleep;
    wreg(8'h02, 8'h80);
    wait_mode(PMS_SLEEP, 80);
    `CHK("pwr_off", 3'b000, {mic_bias_supply_en, adc_power_en, analog_regulator_en})
    creg(8'h77, 8'h83);
    creg(8'h75, 8'he0);
    `CHK("slots_off", 8'h00, slot_on)
    tdm_on <= 1'b0;
    wreg(8'h02, 8'h81);
    wait_mode(PMS_ACTIVE, 60);
    tdm_on <= 1'b1;
    repeat (1200) @(posedge ref_clk);
    `CHK("slots_back", 8'hff, slot_on)
  endtask
  task automatic t_shutdown;
    shutdown_n_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK("mode_shdn", PMS_SHDN, power_mode)
    tdm_on <= 1'b0;
    shutdown_n_pin <= 1'b1;
    wait_mode(PMS_SLEEP, 100);
    creg(8'h75, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    shutdown_n_pin = 1'b0;
    tdm_on = 1'b1;
    general_input = '0;
    repeat (20) @(posedge ref_clk);
    // bit clock runs for the link reset
    tdm_on <= 1'b0;
    rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_power_up;
    t_wake;
    t_config;
    t_audio;
    t_sleep;
    t_shutdown;
    end_of_test;
  end
  // whole run is near 20000 cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    end_of_test;
  end
endmodule // tb
